// File: src/glue_pkg.sv
// constants shared by the clock, reset and interrupt glue
package glue_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned OP_CLK_DIV = 2;
	localparam int unsigned USB_CLK_DIV = 4;
	localparam int unsigned STARTUP_LONG_CYC = 4064;
	localparam int unsigned STARTUP_SHORT_CYC = 224;
	localparam int unsigned STARTUP_W = 12;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_PORT_DIR = 8'h0C;
	localparam logic [7:0] OFS_PULL = 8'h10;
	// status bit positions
	localparam int unsigned ST_IRQ = 0;
	localparam int unsigned ST_LOW_SUPPLY = 1;
	localparam int unsigned ST_READY = 2;
	localparam int unsigned ST_W = 3;
	// ctrl bit positions
	localparam int unsigned CTRL_ACK = 0;
	localparam int unsigned CTRL_CMP_EN = 1;
	// port widths
	localparam int unsigned PORT_A_W = 8;
	localparam int unsigned PORT_B_W = 7;
	localparam int unsigned PORT_C_W = 4;
	localparam int unsigned DIR_W = PORT_A_W + PORT_B_W + PORT_C_W;
	// reset values
	localparam logic [ST_W-1:0] MASK_RST = 3'h0;
	localparam logic [DIR_W-1:0] DIR_RST = 19'h00000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_RESET, ST_STARTUP, ST_RUN} boot_e;
endpackage

// File: src/mcu_glue.sv
// clock division, start-up delay, reset pin and interrupt request glue
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - internal operating enable is the input clock divided by two
// - usb bit clock enable is the input clock divided by four
// - after start-up hold off for 4064 or 224 bus cycles, by option
// - reset pin low returns every register but the low-supply flag and pin synchronisers to its start-up state
// - low-voltage reset drives the reset pin low as an output
// - build option enables low-voltage reset; disabled means droop is ignored
// - build option: falling edge only, or falling edge plus low level
// - build option ors each port a bit 0..3 into the interrupt request
// - the chosen sensitivity applies equally to ored port pins
// - port a interrupt capability enabled or disabled as a whole
// - all port a, b, c lines are inputs after any reset
// - port pull resistors connectable by a build option
// - watchdog enabled or disabled by a build option
// - port c bit 0 is compare output, port b bit 0 capture input
// - port b bits 1 and 2 are open-drain, low drive only
module mcu_glue #(
	parameter bit LONG_STARTUP = 1'b1,
	parameter bit LOW_SUPPLY_RESET_EN = 1'b1,
	parameter bit LEVEL_MODE = 1'b0,
	parameter logic [3:0] PA_IRQ_SEL = 4'hF,
	parameter bit PA_IRQ_EN = 1'b1,
	parameter bit PULL_EN = 1'b1,
	parameter bit WATCHDOG_EN = 1'b1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock enables and system state
	output logic op_clk_en,
	output logic usb_clk_en,
	output logic cpu_run,
	output logic watchdog_function_en,
	output logic pull_resistors_en,
	output logic irq_out,
	// reset pin, low supply detector, interrupt pins
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	input wire logic low_supply_detect,
	input wire logic irq_pin,
	input wire logic [3:0] port_a_low_nibble,
	// timer sharing
	input wire logic port_b_bit0,
	output logic timer_capture_input,
	input wire logic timer_compare_output,
	output logic port_c_bit0_out,
	// port direction, 1 = output
	output logic [glue_pkg::DIR_W-1:0] port_dir,
	output logic [1:0] port_b_od_oe_n
);
	import glue_pkg::*;

	localparam int unsigned STARTUP_CYC = LONG_STARTUP ? STARTUP_LONG_CYC : STARTUP_SHORT_CYC;

	// ==========================================================
	// pin synchronisers, three flops, change once second and third agree
	logic [2:0] rst_sync, lvd_sync, irq_sync;
	logic [2:0] pa_sync [4];
	logic rst_pin_low, lvd_low, irq_low_s;
	logic [3:0] pa_low;

	always_ff @(posedge aclk) begin
		rst_sync <= {rst_sync[1:0], reset_pin_in};
		lvd_sync <= {lvd_sync[1:0], low_supply_detect};
		irq_sync <= {irq_sync[1:0], irq_pin};
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pa
			always_ff @(posedge aclk) begin
				pa_sync[gi] <= {pa_sync[gi][1:0], port_a_low_nibble[gi]};
			end
			always_ff @(posedge aclk) begin
				if (pa_sync[gi][2] == pa_sync[gi][1])
					pa_low[gi] <= ~pa_sync[gi][2];
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (rst_sync[2] == rst_sync[1])
			rst_pin_low <= ~rst_sync[2];
		if (lvd_sync[2] == lvd_sync[1])
			lvd_low <= lvd_sync[2];
		if (irq_sync[2] == irq_sync[1])
			irq_low_s <= ~irq_sync[2];
	end

	// ==========================================================
	// internal reset: bus reset, reset pin, or enabled low-voltage detector
	logic low_supply_detector_reset, sys_rst;
	assign low_supply_detector_reset = LOW_SUPPLY_RESET_EN && lvd_low;
	assign sys_rst = !aresetn || rst_pin_low || low_supply_detector_reset;
	// pin driven low only by the detector, so the pin never fights an external pull
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = !low_supply_detector_reset;

	// ==========================================================
	// clock dividers
	logic [1:0] div_cnt;
	always_ff @(posedge aclk) begin
		if (sys_rst)
			div_cnt <= 2'h0;
		else
			div_cnt <= div_cnt + 2'h1;
	end
	assign op_clk_en = div_cnt[0];
	assign usb_clk_en = (div_cnt == 2'(USB_CLK_DIV - 1));

	// ==========================================================
	// start-up delay counted in internal bus cycles
	boot_e boot;
	logic [STARTUP_W-1:0] boot_cnt;
	always_ff @(posedge aclk) begin
		if (sys_rst) begin
			boot <= ST_RESET;
			boot_cnt <= '0;
		end else begin
			unique case (boot)
				ST_RESET: boot <= ST_STARTUP;
				ST_STARTUP: if (op_clk_en) begin
					if (boot_cnt == STARTUP_W'(STARTUP_CYC - 1))
						boot <= ST_RUN;
					else
						boot_cnt <= boot_cnt + 1'b1;
				end
				ST_RUN: boot <= ST_RUN;
			endcase
		end
	end
	assign cpu_run = (boot == ST_RUN);

	// ==========================================================
	// build-time options
	assign watchdog_function_en = WATCHDOG_EN;
	assign pull_resistors_en = PULL_EN;

	// ==========================================================
	// registers
	logic [ST_W-1:0] status, mask;
	logic irq_latch, compare_out_en;
	logic [DIR_W-1:0] dir;
	logic wr_go, rd_go;
	logic [7:0] aw_addr_q;
	logic aw_have, w_have;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;

	// ==========================================================
	// interrupt request qualification
	logic req_low, req_low_d, req_fall, ack;
	assign req_low = irq_low_s || (PA_IRQ_EN && |(pa_low & PA_IRQ_SEL));
	always_ff @(posedge aclk) begin
		if (sys_rst)
			req_low_d <= 1'b0;
		else
			req_low_d <= req_low;
	end
	assign req_fall = req_low && !req_low_d;
	assign ack = wr_go && aw_addr_q == OFS_CTRL && w_strb_q[0] && w_data_q[CTRL_ACK];
	// set wins over acknowledge
	always_ff @(posedge aclk) begin
		if (sys_rst)
			irq_latch <= 1'b0;
		else if (req_fall)
			irq_latch <= 1'b1;
		else if (ack)
			irq_latch <= 1'b0;
	end
	assign irq_out = (irq_latch || (LEVEL_MODE && req_low)) && cpu_run;

	// ==========================================================
	// axi4-lite write path
	// a pending response blocks both channels, so only one write is ever in flight
	assign s_axi_awready = !aw_have && !s_axi_bvalid;
	assign s_axi_wready = !w_have && !s_axi_bvalid;
	assign wr_go = aw_have && w_have && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (sys_rst) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q inside {OFS_STATUS, OFS_MASK, OFS_CTRL, OFS_PORT_DIR,
					OFS_PULL}) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// status: hardware set wins over write-one clear
	logic [ST_W-1:0] st_set, st_clr;
	assign st_set = {cpu_run, 1'b0, req_fall};
	assign st_clr = (wr_go && aw_addr_q == OFS_STATUS && w_strb_q[0]) ? w_data_q[ST_W-1:0] : '0;
	logic low_supply_seen;
	always_ff @(posedge aclk) begin
		// survives its own reset so software can see the cause
		if (!aresetn)
			low_supply_seen <= 1'b0;
		else if (low_supply_detector_reset)
			low_supply_seen <= 1'b1;
		else if (wr_go && aw_addr_q == OFS_STATUS && w_strb_q[0] && w_data_q[ST_LOW_SUPPLY])
			low_supply_seen <= 1'b0;
	end
	always_ff @(posedge aclk) begin
		if (sys_rst)
			status <= '0;
		else
			status <= (status & ~st_clr) | st_set;
	end

	always_ff @(posedge aclk) begin
		if (sys_rst) begin
			mask <= MASK_RST;
			compare_out_en <= 1'b0;
			dir <= DIR_RST;
		end else if (wr_go) begin
			if (aw_addr_q == OFS_MASK && w_strb_q[0])
				mask <= w_data_q[ST_W-1:0];
			if (aw_addr_q == OFS_CTRL && w_strb_q[0])
				compare_out_en <= w_data_q[CTRL_CMP_EN];
			if (aw_addr_q == OFS_PORT_DIR) begin
				if (w_strb_q[0])
					dir[7:0] <= w_data_q[7:0];
				if (w_strb_q[1])
					dir[15:8] <= w_data_q[15:8];
				if (w_strb_q[2])
					dir[DIR_W-1:16] <= w_data_q[DIR_W-1:16];
			end
		end
	end

	logic [ST_W-1:0] status_view;
	assign status_view = {status[ST_READY], low_supply_seen, status[ST_IRQ]};
	logic irq_sw;
	assign irq_sw = |(status_view & mask);

	// ==========================================================
	// axi4-lite read path
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_STATUS: s_axi_rdata <= 32'(status_view);
				OFS_MASK: s_axi_rdata <= 32'(mask);
				OFS_CTRL: s_axi_rdata <= 32'({compare_out_en, irq_out | irq_sw});
				OFS_PORT_DIR: s_axi_rdata <= 32'(dir);
				OFS_PULL: s_axi_rdata <= 32'({WATCHDOG_EN, PULL_EN});
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ==========================================================
	// ports and pin sharing
	assign port_dir = dir;
	assign timer_capture_input = port_b_bit0;
	assign port_c_bit0_out = compare_out_en ? timer_compare_output : 1'b0;
	// open-drain: enable only when direction is output, data is always low
	assign port_b_od_oe_n = ~dir[PORT_A_W+2:PORT_A_W+1];

	// ==========================================================
	// checks
	// interrupt request
	ack_clears_a: assert property (@(posedge aclk) disable iff (sys_rst)
		ack && !req_fall |=> !irq_latch)
		else $error("ack did not clear request");
	fall_latches_a: assert property (@(posedge aclk) disable iff (sys_rst)
		req_fall |=> irq_latch)
		else $error("edge not latched");
	status_set_a: assert property (@(posedge aclk) disable iff (sys_rst)
		req_fall |=> status[ST_IRQ])
		else $error("edge not recorded in status");
	level_holds_a: assert property (@(posedge aclk) disable iff (sys_rst)
		LEVEL_MODE && req_low && cpu_run |-> irq_out)
		else $error("level lost");
	edge_only_a: assert property (@(posedge aclk) disable iff (sys_rst)
		!LEVEL_MODE && !irq_latch |-> !irq_out)
		else $error("request without a latched edge");
	pa_off_a: assert property (@(posedge aclk) disable iff (sys_rst)
		!PA_IRQ_EN && !irq_low_s |-> !req_low)
		else $error("port a leaks");

	// dividers and start-up
	op_div_a: assert property (@(posedge aclk) disable iff (sys_rst)
		op_clk_en |=> !op_clk_en ##1 op_clk_en)
		else $error("op divider wrong");
	usb_div_a: assert property (@(posedge aclk) disable iff (sys_rst)
		usb_clk_en |=> !usb_clk_en [*3] ##1 usb_clk_en)
		else $error("usb divider wrong");
	div_reset_a: assert property (@(posedge aclk)
		$fell(sys_rst) |-> !op_clk_en && !usb_clk_en)
		else $error("dividers not restarted");
	run_late_a: assert property (@(posedge aclk) disable iff (sys_rst)
		$rose(cpu_run) |-> $past(boot_cnt) == STARTUP_W'(STARTUP_CYC - 1))
		else $error("start-up delay wrong");
	run_hold_a: assert property (@(posedge aclk) disable iff (sys_rst)
		boot_cnt != STARTUP_W'(STARTUP_CYC - 1) |-> !cpu_run)
		else $error("run before start-up delay");

	// reset pin and ports
	droop_drive_a: assert property (@(posedge aclk)
		low_supply_detector_reset |-> !reset_pin_oe_n && !reset_pin_out)
		else $error("reset pin not driven");
	dir_reset_a: assert property (@(posedge aclk)
		$past(sys_rst) |-> port_dir == '0)
		else $error("ports not inputs after reset");
	od_low_a: assert property (@(posedge aclk)
		!port_dir[PORT_A_W+1] |-> port_b_od_oe_n[0])
		else $error("open drain drives");
	cmp_off_a: assert property (@(posedge aclk)
		!compare_out_en |-> !port_c_bit0_out)
		else $error("compare output leaks");

	// main scenarios
	cover_edge_c: cover property (@(posedge aclk) disable iff (sys_rst) req_fall ##1 ack);
	cover_run_c: cover property (@(posedge aclk) disable iff (sys_rst) $rose(cpu_run));
	cover_droop_c: cover property (@(posedge aclk) low_supply_detector_reset);
	cover_pin_c: cover property (@(posedge aclk) rst_pin_low);
	cover_ack_c: cover property (@(posedge aclk) disable iff (sys_rst) ack);
endmodule

// File: verification/board_model.sv
// board-side sources for the reset pin, supply detector and interrupt lines
`timescale 1ns/1ps
module board_model (
	// commands from the bench
	input wire logic hold_rst,
	input wire logic droop,
	input wire logic [4:0] lines,
	// device pins
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	output logic reset_pin_in,
	output logic low_supply_detect,
	output logic irq_pin,
	output logic [3:0] port_a_low_nibble
);
	// ====
	// pins
	// pull-up gives high unless the board or the device pulls low
	assign reset_pin_in = reset_pin_oe_n ? !hold_rst : reset_pin_out;
	assign low_supply_detect = droop;
	// active-low request lines idle high
	assign irq_pin = lines[0];
	assign port_a_low_nibble = lines[4:1];
endmodule

// File: verification/test_mcu_glue.sv
// self-checking bench for the clock, reset and interrupt glue
`timescale 1ns/1ps
module test_mcu_glue;
	import glue_pkg::*;
	// ====
	// signals
	logic aclk = 0, aresetn = 0, hold_rst = 0, droop = 0;
	logic [4:0] lines = 5'h1F;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	// response ready stays high, so back-to-back calls never touch it twice in one step
	logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, od_oe_n;
	logic op_en, usb_en, cpu_run, wd_en, pull_en, irq_out;
	logic rp_in, rp_out, rp_oe_n, lsd, irq_pin, cap_in, cmp_out = 0, pcb0, pb0 = 0;
	logic [3:0] pa;
	logic [DIR_W-1:0] port_dir;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] seed = 32'hFD02, d;
	int mismatches = 0, comparisons = 0, cyc = 0, n, c1, c2;
	initial forever #5 aclk = ~aclk;
	mcu_glue #(.LONG_STARTUP(1'b0)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.op_clk_en(op_en), .usb_clk_en(usb_en), .cpu_run(cpu_run),
		.watchdog_function_en(wd_en), .pull_resistors_en(pull_en), .irq_out(irq_out),
		.reset_pin_in(rp_in), .reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n),
		.low_supply_detect(lsd), .irq_pin(irq_pin), .port_a_low_nibble(pa),
		.port_b_bit0(pb0), .timer_capture_input(cap_in), .timer_compare_output(cmp_out),
		.port_c_bit0_out(pcb0), .port_dir(port_dir), .port_b_od_oe_n(od_oe_n));
	board_model brd_u (.hold_rst(hold_rst), .droop(droop), .lines(lines),
		.reset_pin_out(rp_out), .reset_pin_oe_n(rp_oe_n), .reset_pin_in(rp_in),
		.low_supply_detect(lsd), .irq_pin(irq_pin), .port_a_low_nibble(pa));
	// ====
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ready is looked at on the falling edge, where it equals its rising-edge value
	task wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] rs);
		logic ah, wh, b;
		exp_q.push_back({rs, 32'h0});
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1;
		wvalid <= 1;
		b = 0;
		while (!b) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			b = bvalid;
			@(posedge aclk);
			if (ah) awvalid <= 0;
			if (wh) wvalid <= 0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] rs);
		logic ah, r;
		exp_q.push_back({rs, ex});
		araddr <= a;
		arvalid <= 1;
		r = 0;
		while (!r) begin
			@(negedge aclk);
			ah = arvalid && arready;
			r = rvalid;
			@(posedge aclk);
			if (ah) arvalid <= 0;
		end
	endtask
	task wait_run();
		n = 0;
		while (cpu_run !== 1'b1) begin
			@(negedge aclk);
			n++;
		end
		@(posedge aclk);
	endtask
	task cycles(input int k);
		repeat (k) @(posedge aclk);
	endtask
	// ====
	// result watcher: oldest note against each answer
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			stop_test();
		end
		if (bvalid === 1'b1 && bready) begin
			e = exp_q.pop_front();
			chk("bresp", e[33:32], bresp);
		end
		if (rvalid === 1'b1 && rready) begin
			e = exp_q.pop_front();
			chk("rdata", e[31:0], rdata);
			chk("rresp", e[33:32], rresp);
		end
	end
	// ====
	// tests
	initial begin
		cycles(20);
		aresetn <= 1;
		wait_run();
		chk("startup", 1, n >= 448 && n <= 460);
		$display("test startup done");
		c1 = 0;
		c2 = 0;
		repeat (40) begin
			@(negedge aclk);
			c1 += op_en;
			c2 += usb_en;
		end
		@(posedge aclk);
		chk("op_clk_en", 20, c1);
		chk("usb_clk_en", 10, c2);
		rd(OFS_MASK, MASK_RST, RESP_OKAY);
		rd(OFS_PORT_DIR, DIR_RST, RESP_OKAY);
		rd(OFS_PULL, 32'h3, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_OKAY | RESP_SLVERR);
		wr(8'h14, 32'h1, RESP_SLVERR);
		$display("test clocks and registers done");
		for (int i = 0; i < 5; i++) begin
			lines <= ~(5'h01 << i);
			cycles(8);
			chk("irq_set", 1, irq_out);
			lines <= 5'h1F;
			cycles(3);
			chk("irq_held", 1, irq_out);
			rd(OFS_STATUS, 32'h5, RESP_OKAY);
			wr(OFS_CTRL, 32'h1, RESP_OKAY);
			wr(OFS_STATUS, 32'h1, RESP_OKAY);
			cycles(2);
			chk("irq_clr", 0, irq_out);
			rd(OFS_STATUS, 32'h4, RESP_OKAY);
		end
		lines <= 5'h1E;
		cycles(8);
		wr(OFS_CTRL, 32'h1, RESP_OKAY);
		cycles(4);
		chk("edge_only", 0, irq_out);
		wr(OFS_MASK, 32'h4, RESP_OKAY);
		rd(OFS_CTRL, 32'h1, RESP_OKAY);
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		lines <= 5'h1F;
		wr(OFS_STATUS, 32'h1, RESP_OKAY);
		$display("test interrupts done");
		d = xs() & 32'h7FFFF;
		wr(OFS_PORT_DIR, d, RESP_OKAY);
		rd(OFS_PORT_DIR, d, RESP_OKAY);
		chk("port_dir", d, port_dir);
		chk("od_oe_n", {30'h0, ~d[10:9]}, od_oe_n);
		wr(OFS_CTRL, 32'h2, RESP_OKAY);
		cmp_out <= 1;
		pb0 <= 1;
		cycles(1);
		chk("compare_out", 1, pcb0);
		chk("capture_in", 1, cap_in);
		rd(OFS_CTRL, 32'h2, RESP_OKAY);
		wr(OFS_CTRL, 32'h0, RESP_OKAY);
		chk("compare_off", 0, pcb0);
		$display("test ports done");
		hold_rst <= 1;
		cycles(6);
		chk("dir_in_reset", 0, port_dir);
		chk("run_in_reset", 0, cpu_run);
		hold_rst <= 0;
		wait_run();
		rd(OFS_PORT_DIR, 32'h0, RESP_OKAY);
		droop <= 1;
		cycles(6);
		chk("reset_pin_oe_n", 0, rp_oe_n);
		chk("reset_pin_out", 0, rp_out);
		droop <= 0;
		wait_run();
		rd(OFS_STATUS, 32'h6, RESP_OKAY);
		$display("test resets done");
		cycles(3);
		stop_test();
	end
endmodule
